// ---- src/power_ref_test_consts.svh ----
// register offsets, field positions and reset values for the config bank
`ifndef POWER_REF_TEST_CONSTS_SVH
`define POWER_REF_TEST_CONSTS_SVH

// printed offsets are word indices; byte address is four times the index
`define PWR_SLEEP_IDX 8'h1A
`define REF_TEST_IDX 8'h1B
`define PWR_SLEEP_RESET 16'h0020
`define REF_TEST_RESET 16'h0000
`define VCO_TUNE_MSB 15
`define VCO_TUNE_LSB 10
`define BIAS_SLEEP_BIT 7
`define TSENSE_SLEEP_BIT 6
`define SYNTH_SLEEP_BIT 5
`define CLKRECV_SLEEP_BIT 4
`define CHAN_SLEEP_TOP 3
`define EXTREF_BIT 15
`define FUSE_SLEEP_BIT 11
`define ATEST_MSB 5
`define ATEST_LSB 0
`define ADDR_WIDTH 10

`endif

// ---- src/power_ref_test_pkg.sv ----
// types shared by the config bank files
package power_ref_test_pkg;
    typedef logic [15:0] cfg_word_t;
    typedef logic [5:0] atest_code_t;
    typedef enum logic [1:0] {BUS_IDLE, BUS_ANSWER} bus_state_e;
endpackage : power_ref_test_pkg

// ---- src/chan_sleep_decode.sv ----
// per-channel converter sleep outputs
`timescale 1ns/1ps
`include "power_ref_test_consts.svh"

module chan_sleep_decode #(
    parameter int CHANNELS = 4
) (
    input wire logic core_clk, // clock
    input wire logic reset, // synchronous reset, active high
    input wire logic clkEn, // clock enable
    input wire logic [CHANNELS-1:0] sleepBits, // register bits 3..0
    output logic [CHANNELS-1:0] chanSleep // index 0 is first channel
);
    // ----------------------------------------
    // bit 3 drives the first channel, bit 0 the fourth
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < CHANNELS; i++)
        begin : g_chan
            always_ff @(posedge core_clk)
            begin
                if (reset)
                    chanSleep[i] <= 1'b0;
                else if (clkEn)
                    chanSleep[i] <= sleepBits[CHANNELS-1-i]; // see (RULE9)
            end
        end
    endgenerate
endmodule : chan_sleep_decode

// ---- src/power_ref_test_config_regs.sv ----
// power, reference and analog test configuration registers
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`include "power_ref_test_consts.svh"

// How it works
// (RULE1) the power register resets to 0x0020.
// (RULE2) the reference and test register resets to zero.
// (RULE3) bits 15:10 of the power register drive the coarse tuning code.
// (RULE4) bit 7 of the power register powers down the bias amplifier.
// (RULE5) bit 6 of the power register switches off the temperature sensor.
// (RULE6) bit 5 of the power register holds the synthesizer asleep.
// (RULE7) bit 4 of the power register puts the clock receiver to sleep.
// (RULE8) that same bit also sleeps the sync strobe receiver.
// (RULE9) bits 3 to 0 sleep channels one to four in that order.
// (RULE10) bit 15 of the reference register picks external over internal.
// (RULE11) bit 11 of the reference register puts the fuse bank to sleep.
// (RULE12) a nonzero code in bits 5:0 routes a die voltage to the pin.
// (RULE13) the outside leaves the pin floating while test mode is on.
// (RULE14) software writes reserved bits with defaults and ignores them.
module power_ref_test_config_regs #(
    parameter int CHANNELS = 4
) (
    input wire logic core_clk, // 20 MHz clock
    input wire logic reset, // synchronous reset, active high
    input wire logic clkEn, // freezes all state while low
    input wire logic [`ADDR_WIDTH-1:0] address, // avalon byte address
    input wire logic read, // avalon read
    input wire logic write, // avalon write
    input wire logic [31:0] writedata, // avalon write data
    input wire logic [3:0] byteenable, // avalon byte enables
    output logic [31:0] readdata, // avalon read data
    output logic waitrequest, // avalon wait
    output logic [1:0] response, // 00 okay, 10 slave error
    output logic [5:0] vcoCoarseTune, // synthesizer coarse code
    output logic biasPowerdown, // bias amplifier sleep
    output logic tsenseOff, // temperature sensor off
    output logic synthSleep, // loop synthesizer sleep
    output logic clkRecvSleep, // clock input receiver sleep
    output logic syncStrobeSleep, // sync_strobe_input receiver sleep
    output logic [CHANNELS-1:0] chanSleep, // chan1..4_powerdown
    output logic extRefSelect, // 1 external reference
    output logic fuseSleep, // fuse bank sleep
    output logic atestActive, // analog test mode on
    output power_ref_test_pkg::atest_code_t atestSelect, // die voltage code
    output logic transmitEnableOe // high drives transmit_enable_pin
);
    import power_ref_test_pkg::*;

    // ----------------------------------------
    // register storage and decoded fields
    // ----------------------------------------
    cfg_word_t pwrSleep_reg;
    cfg_word_t refTest_reg;
    bus_state_e busState_reg;
    logic [7:0] wordIdx;
    logic hitPwr;
    logic hitRef;
    logic accept;
    logic wrPwr;
    logic wrRef;
    cfg_word_t wrMask;
    cfg_word_t rdWord;
    logic [1:0] rdCode;
    logic [5:0] tuneField;
    logic biasField;
    logic tsenseField;
    logic synthField;
    logic clkRecvField;
    logic extRefField;
    logic fuseField;
    atest_code_t atestField;
    logic atestOn;

    // ----------------------------------------
    // address decode and write strobes
    // ----------------------------------------
    assign wordIdx = address[`ADDR_WIDTH-1:2];
    assign hitPwr = (wordIdx == `PWR_SLEEP_IDX);
    assign hitRef = (wordIdx == `REF_TEST_IDX);
    // enable low stalls the handshake as well as the registers
    assign accept = clkEn && (busState_reg == BUS_IDLE) && (read || write);
    assign wrPwr = accept && write && hitPwr;
    assign wrRef = accept && write && hitRef;
    // byte lane 0 covers bits 7:0, lane 1 bits 15:8
    assign wrMask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
            pwrSleep_reg <= `PWR_SLEEP_RESET; // see (RULE1)
        else if (wrPwr)
            pwrSleep_reg <= (pwrSleep_reg & ~wrMask)
                | (writedata[15:0] & wrMask);
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            refTest_reg <= `REF_TEST_RESET; // see (RULE2)
        else if (wrRef)
            refTest_reg <= (refTest_reg & ~wrMask)
                | (writedata[15:0] & wrMask);
    end

    // ----------------------------------------
    // field decode
    // ----------------------------------------
    assign tuneField = pwrSleep_reg[`VCO_TUNE_MSB:`VCO_TUNE_LSB];
    assign biasField = pwrSleep_reg[`BIAS_SLEEP_BIT];
    assign tsenseField = pwrSleep_reg[`TSENSE_SLEEP_BIT];
    assign synthField = pwrSleep_reg[`SYNTH_SLEEP_BIT];
    assign clkRecvField = pwrSleep_reg[`CLKRECV_SLEEP_BIT];
    assign extRefField = refTest_reg[`EXTREF_BIT];
    assign fuseField = refTest_reg[`FUSE_SLEEP_BIT];
    assign atestField = refTest_reg[`ATEST_MSB:`ATEST_LSB];
    // any nonzero code turns the test path on
    assign atestOn = |atestField;

    // ----------------------------------------
    // read mux: unmapped words read zero with an error code
    // ----------------------------------------
    always_comb
    begin
        rdWord = 16'h0000;
        rdCode = 2'h0;
        if (hitPwr)
            rdWord = pwrSleep_reg;
        else if (hitRef)
            rdWord = refTest_reg;
        else
            rdCode = 2'h2;
    end

    // ----------------------------------------
    // avalon slave: one wait cycle, answer on the next edge
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
            busState_reg <= BUS_IDLE;
        else if (clkEn)
        begin
            case (busState_reg)
                BUS_IDLE:
                    if (read || write)
                        busState_reg <= BUS_ANSWER;
                BUS_ANSWER:
                    busState_reg <= BUS_IDLE;
                default:
                    busState_reg <= BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            waitrequest <= 1'b1;
        end
        else if (clkEn)
        begin
            waitrequest <= !(busState_reg == BUS_IDLE && (read || write));
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            readdata <= 32'h00000000;
        end
        else if (accept)
        begin
            readdata <= {16'h0000, rdWord};
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            response <= 2'h0;
        end
        else if (accept)
        begin
            response <= rdCode;
        end
    end

    // ----------------------------------------
    // synthesizer, bias and sensor controls
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            vcoCoarseTune <= 6'h00;
        end
        else if (clkEn)
        begin
            vcoCoarseTune <= tuneField; // see (RULE3)
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            biasPowerdown <= 1'b0;
        end
        else if (clkEn)
        begin
            biasPowerdown <= biasField; // see (RULE4)
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            tsenseOff <= 1'b0;
        end
        else if (clkEn)
        begin
            tsenseOff <= tsenseField; // see (RULE5)
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            synthSleep <= 1'b1;
        end
        else if (clkEn)
        begin
            synthSleep <= synthField; // see (RULE6)
        end
    end

    // ----------------------------------------
    // receivers and converter channels
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            clkRecvSleep <= 1'b0;
        end
        else if (clkEn)
        begin
            clkRecvSleep <= clkRecvField; // see (RULE7)
        end
    end

    // one bit sleeps both receivers
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            syncStrobeSleep <= 1'b0;
        end
        else if (clkEn)
        begin
            syncStrobeSleep <= clkRecvField; // see (RULE8)
        end
    end

    chan_sleep_decode #(
        .CHANNELS(CHANNELS)
    ) u_chan (
        .core_clk(core_clk),
        .reset(reset),
        .clkEn(clkEn),
        .sleepBits(pwrSleep_reg[`CHAN_SLEEP_TOP:0]), // see (RULE9)
        .chanSleep(chanSleep)
    );

    // ----------------------------------------
    // reference source and fuse bank
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            extRefSelect <= 1'b0;
        end
        else if (clkEn)
        begin
            extRefSelect <= extRefField; // see (RULE10)
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            fuseSleep <= 1'b0;
        end
        else if (clkEn)
        begin
            fuseSleep <= fuseField; // see (RULE11)
        end
    end

    // ----------------------------------------
    // analog test: pin becomes a measurement node, pin driver enabled while the code is nonzero
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            atestSelect <= 6'h00;
        end
        else if (clkEn)
        begin
            atestSelect <= atestField; // see (RULE12)
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            atestActive <= 1'b0;
        end
        else if (clkEn)
        begin
            atestActive <= atestOn; // see (RULE12)
        end
    end

    // outside leaves pin floating, so only the device drives it
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            transmitEnableOe <= 1'b0;
        end
        else if (clkEn)
        begin
            transmitEnableOe <= atestOn; // see (RULE12)
        end
    end
endmodule : power_ref_test_config_regs

// ---- bench/power_ref_test_config_regs_props.sv ----
// assertions on the config bank outputs
`timescale 1ns/1ps
`include "power_ref_test_consts.svh"

module power_ref_test_config_regs_props #(
    parameter int CHANNELS = 4
) (
    input wire logic core_clk, // clock
    input wire logic reset, // reset
    input wire logic [`ADDR_WIDTH-1:0] address, // addr
    input wire logic write, // write
    input wire logic [31:0] writedata, // data
    input wire logic [3:0] byteenable, // lanes
    input wire logic waitrequest, // wait
    input wire logic [5:0] vcoCoarseTune, // tune
    input wire logic biasPowerdown, // bias
    input wire logic tsenseOff, // sensor
    input wire logic synthSleep, // synth
    input wire logic clkRecvSleep, // clock rx
    input wire logic syncStrobeSleep, // strobe rx
    input wire logic [CHANNELS-1:0] chanSleep, // channels
    input wire logic extRefSelect, // reference
    input wire logic fuseSleep, // fuses
    input wire logic atestActive, // test on
    input wire power_ref_test_pkg::atest_code_t atestSelect, // code
    input wire logic transmitEnableOe // pin drive
);
    import power_ref_test_pkg::*;
    wire logic pwDone = write && !waitrequest &&
        address[9:2] == `PWR_SLEEP_IDX;
    wire logic rfDone = write && !waitrequest &&
        address[9:2] == `REF_TEST_IDX;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    chk_strobe_pair: assert property
        (clkRecvSleep == syncStrobeSleep) else $error("strobe rx split");
    chk_test_flag: assert property
        (atestActive == (|atestSelect)) else $error("test flag wrong");
    chk_pin_drive: assert property
        (transmitEnableOe == atestActive) else $error("pin drive wrong");
    chk_pwr_reset: assert property
        ($past(reset) |-> synthSleep && vcoCoarseTune == 6'h00 &&
        !biasPowerdown && !tsenseOff && !clkRecvSleep && chanSleep == '0)
        else $error("power reset value wrong");
    chk_ref_reset: assert property
        ($past(reset) |-> !extRefSelect && !fuseSleep &&
        atestSelect == 6'h00) else $error("ref reset value wrong");
    chk_tune_write: assert property
        (pwDone && byteenable[1] |=>
        vcoCoarseTune == $past(writedata[15:10]))
        else $error("tune code wrong");
    chk_power_bits: assert property
        (pwDone && byteenable[0] |=>
        {biasPowerdown, tsenseOff, synthSleep, clkRecvSleep}
        == $past(writedata[7:4])) else $error("sleep bits wrong");
    chk_chan_order: assert property
        (pwDone && byteenable[0] |=> chanSleep == {$past(writedata[0]),
        $past(writedata[1]), $past(writedata[2]), $past(writedata[3])})
        else $error("channel order wrong");
    chk_ref_write: assert property
        (rfDone && byteenable[1:0] == 2'h3 |=>
        extRefSelect == $past(writedata[15]) &&
        fuseSleep == $past(writedata[11]) &&
        atestSelect == $past(writedata[5:0])) else $error("ref bits wrong");
    cover property (pwDone);
    cover property (pwDone && !byteenable[0]);
    cover property (rfDone);
    cover property ($rose(atestActive));
endmodule : power_ref_test_config_regs_props

bind power_ref_test_config_regs power_ref_test_config_regs_props
    #(.CHANNELS(CHANNELS)) chk_u (.*);

// ---- bench/power_ref_test_config_regs_tb.sv ----
// self-checking bench for the config bank
`timescale 1ns/1ps
`include "power_ref_test_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end

module power_ref_test_config_regs_tb;
    import power_ref_test_pkg::*;
    localparam logic [9:0] PW_ADDR = {`PWR_SLEEP_IDX, 2'b00};
    localparam logic [9:0] RF_ADDR = {`REF_TEST_IDX, 2'b00};
    logic core_clk, reset, clkEn, read, write, waitrequest;
    logic [9:0] address;
    logic [31:0] writedata, readdata, rdData;
    logic [3:0] byteenable, chanSleep;
    logic [1:0] response, rdResp;
    logic [5:0] vcoCoarseTune;
    atest_code_t atestSelect;
    logic biasPowerdown, tsenseOff, synthSleep, clkRecvSleep;
    logic syncStrobeSleep, extRefSelect, fuseSleep, atestActive;
    logic transmitEnableOe;
    logic [15:0] pw, rf;
    int n_fail = 0;
    int n_tests = 0;

    power_ref_test_config_regs #(.CHANNELS(4)) dut_u (
        .core_clk(core_clk), .reset(reset), .clkEn(clkEn),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .response(response), .vcoCoarseTune(vcoCoarseTune),
        .biasPowerdown(biasPowerdown), .tsenseOff(tsenseOff),
        .synthSleep(synthSleep), .clkRecvSleep(clkRecvSleep),
        .syncStrobeSleep(syncStrobeSleep), .chanSleep(chanSleep),
        .extRefSelect(extRefSelect), .fuseSleep(fuseSleep),
        .atestActive(atestActive), .atestSelect(atestSelect),
        .transmitEnableOe(transmitEnableOe)); // driven high while analog test is on

    task automatic wrap_up();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic bus_op(input logic wr, input logic [9:0] a,
        input logic [15:0] d);
        @(posedge core_clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= {16'h0000, d};
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        rdData = readdata;
        rdResp = response;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus_op

    function automatic logic [3:0] rev4(input logic [3:0] v);
        return {v[0], v[1], v[2], v[3]};
    endfunction : rev4

    task automatic check_all(input logic [15:0] p, input logic [15:0] r);
        bus_op(1'b0, PW_ADDR, 16'h0000);
        `CHK(rdData, {16'h0000, p})
        bus_op(1'b0, RF_ADDR, 16'h0000);
        `CHK(rdData, {16'h0000, r})
        `CHK(vcoCoarseTune, p[15:10])
        `CHK(biasPowerdown, p[7])
        `CHK(tsenseOff, p[6])
        `CHK(synthSleep, p[5])
        `CHK(clkRecvSleep, p[4])
        `CHK(syncStrobeSleep, p[4])
        `CHK(chanSleep, rev4(p[3:0]))
        `CHK(extRefSelect, r[15])
        `CHK(fuseSleep, r[11])
        `CHK(atestSelect, r[5:0])
        `CHK(atestActive, |r[5:0])
        `CHK(transmitEnableOe, |r[5:0])
    endtask : check_all

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial
    begin
        repeat (3000) @(posedge core_clk);
        n_fail++;
        wrap_up();
    end

    initial
    begin
        reset = 1'b1;
        clkEn = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 10'h000;
        writedata = 32'h00000000;
        byteenable = 4'hF;
        void'($urandom(98));
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        check_all(16'h0020, 16'h0000);
        for (int i = 0; i < 24; i++)
        begin
            pw = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
            rf = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0001 : 16'($urandom);
            pw = pw & 16'hFCFF;
            rf = rf & 16'h883F;
            bus_op(1'b1, PW_ADDR, pw);
            bus_op(1'b1, RF_ADDR, rf);
            check_all(pw, rf);
        end
        // unmapped place: error code, nothing stored
        bus_op(1'b1, 10'h070, 16'h1234);
        `CHK(rdResp, 2'b10)
        bus_op(1'b0, 10'h070, 16'h0000);
        `CHK(rdResp, 2'b10)
        `CHK(rdData, 32'h00000000)
        check_all(pw, rf);
        // enable low: the request waits and nothing is stored
        pw = pw ^ 16'h0010;
        clkEn <= 1'b0;
        fork
            bus_op(1'b1, PW_ADDR, pw);
            begin
                repeat (6) @(posedge core_clk);
                `CHK(waitrequest, 1'b1)
                `CHK(clkRecvSleep, !pw[4])
                clkEn <= 1'b1;
            end
        join
        // upper byte lane only
        byteenable <= 4'h2;
        bus_op(1'b1, PW_ADDR, {8'h5C, ~pw[7:0]});
        byteenable <= 4'hF;
        pw = {8'h5C, pw[7:0]};
        check_all(pw, rf);
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        check_all(16'h0020, 16'h0000);
        wrap_up();
    end
endmodule : power_ref_test_config_regs_tb
